// *** design/fcpm_warmup_timer.sv ***
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
package fcpm_pkg;

  // register byte addresses on the ahb-lite bus
  localparam logic [7:0]  FCPM_CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  FCPM_STATUS_ADDR = 8'h04;
  localparam int          FCPM_ADDR_W      = 8;

  // control register field positions
  localparam int          FCPM_MAN_BIT     = 0;
  localparam int          FCPM_AUTO_BIT    = 1;
  // status register field positions
  localparam int          FCPM_READY_BIT   = 1;
  localparam int          FCPM_STALL_BIT   = 2;

  // reset values
  localparam logic        FCPM_MAN_RST     = 1'b1;
  localparam logic        FCPM_AUTO_RST    = 1'b0;

  // warm-up lengths as powers of two (2^EXP) in periods of the selected source clock
  localparam int          FCPM_FAST_EXP    = 10;
  localparam int          FCPM_SLOW_EXP    = 3;
  localparam int          FCPM_CNT_W       = FCPM_FAST_EXP + 1;
  localparam logic [FCPM_CNT_W-1:0] FCPM_FAST_LAST = (FCPM_CNT_W)'((1 << FCPM_FAST_EXP) - 1);
  localparam logic [FCPM_CNT_W-1:0] FCPM_SLOW_LAST = (FCPM_CNT_W)'((1 << FCPM_SLOW_EXP) - 1);

  localparam logic [7:0]  FCPM_BLANK_BYTE  = 8'hff;
  localparam logic [1:0]  FCPM_HTRANS_NSEQ = 2'h2;

  // operating-mode events from the mode and clock controller, one-cycle pulses
  typedef struct packed {
    logic stop_enter;
    logic stop_exit;
    logic halt_enter;
    logic halt_exit;
    logic nmi;
  } fcpm_mode_t;

  // flash read port from the cpu
  typedef struct packed {
    logic       req;
    logic       fetch;
    logic [7:0] rdata;
  } fcpm_flash_req_t;

  typedef enum logic [5:0] {
    FCPM_OFF       = 6'h01,
    FCPM_WARM_SW   = 6'h02,
    FCPM_WARM_AUTO = 6'h04,
    FCPM_ON        = 6'h08,
    FCPM_HALT_OFF  = 6'h10,
    FCPM_STOP_OFF  = 6'h20
  } fcpm_state_t;

endpackage : fcpm_pkg

////////////////////////////////////////////////////////////////////////////////
// counts ticks of the selected clock from a start pulse, done is a pulse
module fcpm_warmup_timer
  import fcpm_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic start,
  input  wire logic run,
  input  wire logic slow_sel,
  input  wire logic fast_tick,
  input  wire logic slow_tick,
  output logic      done
);

  logic [FCPM_CNT_W-1:0] cnt_reg;
  logic [FCPM_CNT_W-1:0] cnt_next;
  wire logic             tick_w;
  wire logic [FCPM_CNT_W-1:0] last_w;

  assign tick_w = slow_sel ? slow_tick : fast_tick;
  assign last_w = slow_sel ? FCPM_SLOW_LAST : FCPM_FAST_LAST;
  assign done   = run && !start && tick_w && (cnt_reg == last_w);

  always_comb begin
    cnt_next = cnt_reg;
    if (start) begin
      cnt_next = '0;
    end else if (run && tick_w) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : fcpm_warmup_timer

`default_nettype wire

// *** design/fcpm_power_manager.sv ***
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`default_nettype none

// Behaviour
// - clearing manual bit cuts power at once
// - ready flag after 2^10 fast/2^3 slow periods
// - software warm-up stalls the cpu only after nmi
// - flash reads give ffh while not ready
// - manual bit written only from ram
// - nmi with power off forces stalled warm-up
// - automatic warm-up halts cpu until done
// - interrupts held back during warm-up wait
// - nmi during polled warm-up stalls until done
// - stop cuts power; release runs stalled warm-up
// - manual bit zero keeps power off through stop
// - auto bit zero: idle/sleep off, stalled warm-up
// - auto bit one: no wait after idle/sleep
// - auto bit acts only with manual bit one
// - auto bit writable from any area
module fcpm_power_manager
  import fcpm_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // cpu and mode controller
  input  wire logic            cpu_in_ram,
  input  wire logic            system_clock_select,
  input  wire fcpm_mode_t      mode_events,
  input  wire fcpm_flash_req_t flash_req,
  // source clocks arriving as pins
  input  wire logic            fast_clock,
  input  wire logic            slow_clock,
  // outputs
  output logic                 flash_power_on,
  output logic                 warmup_ready_flag,
  output logic                 cpu_stall,
  output logic                 interrupt_hold,
  output logic [7:0]           flash_rdata,
  output logic                 flash_rvalid,
  output logic                 soft_interrupt
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [1:0]        fast_sync_reg;
  logic [1:0]        slow_sync_reg;
  logic              fast_prev_reg;
  logic              slow_prev_reg;
  wire logic         fast_tick_w;
  wire logic         slow_tick_w;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_sync_reg <= '0;
      slow_sync_reg <= '0;
      fast_prev_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
    end else begin
      fast_sync_reg <= {fast_sync_reg[0], fast_clock};
      slow_sync_reg <= {slow_sync_reg[0], slow_clock};
      fast_prev_reg <= fast_sync_reg[1];
      slow_prev_reg <= slow_sync_reg[1];
    end
  end

  // one tick per rising edge of each source clock
  assign fast_tick_w = fast_sync_reg[1] && !fast_prev_reg;
  assign slow_tick_w = slow_sync_reg[1] && !slow_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  logic                   dph_wr_reg;
  logic [FCPM_ADDR_W-1:0] dph_addr_reg;
  logic [31:0]            hrdata_reg;
  wire logic              aph_take_w;
  wire logic              aph_read_w;
  wire logic [31:0]       rd_word_w;
  wire logic              wr_ctrl_w;

  function automatic logic [31:0] fcpm_read_mux(
    input logic [FCPM_ADDR_W-1:0] addr,
    input logic                   man,
    input logic                   auto_bit,
    input logic                   ready,
    input logic                   stall
  );
    logic [31:0] word;
    word = '0;
    if (addr == FCPM_CTRL_ADDR) begin
      word[FCPM_MAN_BIT]  = man;
      word[FCPM_AUTO_BIT] = auto_bit;
    end else if (addr == FCPM_STATUS_ADDR) begin
      word[FCPM_READY_BIT] = ready;
      word[FCPM_STALL_BIT] = stall;
    end
    return word;
  endfunction : fcpm_read_mux

  assign aph_take_w = hsel && hready && (htrans == FCPM_HTRANS_NSEQ);
  assign aph_read_w = aph_take_w && !hwrite;
  assign wr_ctrl_w  = dph_wr_reg && (dph_addr_reg == FCPM_CTRL_ADDR);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_reg   <= 1'b0;
      dph_addr_reg <= '0;
    end else begin
      dph_wr_reg   <= aph_take_w && hwrite;
      dph_addr_reg <= haddr[FCPM_ADDR_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control bits
  logic              manual_reg;
  logic              manual_next;
  logic              auto_reg;
  logic              auto_next;
  wire logic         man_wr_ok_w;
  wire logic         man_set_w;
  wire logic         man_clear_w;
  wire logic         nmi_wake_w;

  assign man_wr_ok_w = wr_ctrl_w && cpu_in_ram;
  assign man_set_w   = man_wr_ok_w && hwdata[FCPM_MAN_BIT] && !manual_reg;
  assign man_clear_w = man_wr_ok_w && !hwdata[FCPM_MAN_BIT];
  assign nmi_wake_w  = mode_events.nmi && !manual_reg;

  always_comb begin
    manual_next = manual_reg;
    if (nmi_wake_w) begin
      manual_next = 1'b1;
    end else if (man_wr_ok_w) begin
      manual_next = hwdata[FCPM_MAN_BIT];
    end
  end

  assign auto_next = wr_ctrl_w ? hwdata[FCPM_AUTO_BIT] : auto_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      manual_reg <= FCPM_MAN_RST;
      auto_reg   <= FCPM_AUTO_RST;
    end else begin
      manual_reg <= manual_next;
      auto_reg   <= auto_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power sequencer
  fcpm_state_t       state_reg;
  fcpm_state_t       state_next;
  wire logic         warm_now_w;
  wire logic         warm_next_w;
  wire logic         timer_start_w;
  wire logic         timer_done_w;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FCPM_OFF: begin
        // stop and idle/sleep leave power off here
        if (nmi_wake_w) begin
          state_next = FCPM_WARM_AUTO;
        end else if (man_set_w) begin
          state_next = FCPM_WARM_SW;
        end
      end
      FCPM_WARM_SW: begin
        if (mode_events.nmi) begin
          state_next = FCPM_WARM_AUTO;
        end else if (man_clear_w) begin
          state_next = FCPM_OFF;
        end else if (mode_events.stop_enter) begin
          state_next = FCPM_STOP_OFF;
        end else if (timer_done_w) begin
          state_next = FCPM_ON;
        end
      end
      FCPM_WARM_AUTO: begin
        if (timer_done_w) begin
          state_next = FCPM_ON;
        end
      end
      FCPM_ON: begin
        if (man_clear_w && !mode_events.nmi) begin
          state_next = FCPM_OFF;
        end else if (mode_events.stop_enter) begin
          state_next = FCPM_STOP_OFF;
        end else if (mode_events.halt_enter && !auto_reg) begin
          state_next = FCPM_HALT_OFF;
        end
      end
      FCPM_HALT_OFF: begin
        if (mode_events.halt_exit) begin
          state_next = FCPM_WARM_AUTO;
        end
      end
      FCPM_STOP_OFF: begin
        // stop_exit comes after the oscillator warm-up has finished
        if (mode_events.stop_exit) begin
          state_next = FCPM_WARM_AUTO;
        end
      end
      default: begin
        state_next = FCPM_OFF;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= FCPM_ON;
    end else begin
      state_reg <= state_next;
    end
  end

  assign warm_now_w    = (state_reg == FCPM_WARM_SW) || (state_reg == FCPM_WARM_AUTO);
  assign warm_next_w   = (state_next == FCPM_WARM_SW) || (state_next == FCPM_WARM_AUTO);
  // count restarts only when power comes back, not on sw to auto handover
  assign timer_start_w = warm_next_w && !warm_now_w;

  fcpm_warmup_timer u_timer (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .start     (timer_start_w),
    .run       (warm_now_w),
    .slow_sel  (system_clock_select),
    .fast_tick (fast_tick_w),
    .slow_tick (slow_tick_w),
    .done      (timer_done_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  // status outputs
  logic              power_reg;
  logic              ready_reg;
  logic              stall_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_reg <= 1'b1;
      ready_reg <= 1'b1;
      stall_reg <= 1'b0;
    end else begin
      power_reg <= warm_next_w || (state_next == FCPM_ON);
      ready_reg <= (state_next == FCPM_ON);
      stall_reg <= (state_next == FCPM_WARM_AUTO);
    end
  end

  assign flash_power_on    = power_reg;
  assign warmup_ready_flag = ready_reg;
  assign cpu_stall         = stall_reg;
  assign interrupt_hold    = stall_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (aph_read_w) begin
      hrdata_reg <= rd_word_w;
    end
  end

  assign rd_word_w = fcpm_read_mux(haddr[FCPM_ADDR_W-1:0], manual_reg, auto_reg,
                                   ready_reg, stall_reg);

  //////////////////////////////////////////////////////////////////////////////
  // flash read gating
  logic [7:0]        flash_rdata_reg;
  logic              flash_rvalid_reg;
  logic              soft_int_reg;
  wire logic         blocked_w;

  assign blocked_w = flash_req.req && !ready_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_rdata_reg  <= FCPM_BLANK_BYTE;
      flash_rvalid_reg <= 1'b0;
      soft_int_reg     <= 1'b0;
    end else begin
      flash_rvalid_reg <= flash_req.req;
      soft_int_reg     <= blocked_w && flash_req.fetch;
      if (flash_req.req) begin
        flash_rdata_reg <= ready_reg ? flash_req.rdata : FCPM_BLANK_BYTE;
      end
    end
  end

  assign flash_rdata    = flash_rdata_reg;
  assign flash_rvalid   = flash_rvalid_reg;
  assign soft_interrupt = soft_int_reg;

endmodule : fcpm_power_manager

`default_nettype wire

// *** bench/fcpm_properties.sv ***
`default_nettype none

module fcpm_properties
  import fcpm_pkg::*;
(
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [31:0]     hwdata,
  input wire logic            hready,
  input wire logic            cpu_in_ram,
  input wire fcpm_mode_t      mode_events,
  input wire fcpm_flash_req_t flash_req,
  input wire logic            flash_power_on,
  input wire logic            warmup_ready_flag,
  input wire logic            cpu_stall,
  input wire logic            interrupt_hold,
  input wire logic [7:0]      flash_rdata,
  input wire logic            flash_rvalid,
  input wire logic            soft_interrupt
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // a control write is in its data phase
  logic wr_ctrl_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_ctrl_reg <= 1'b0;
    else if (hready) wr_ctrl_reg <= hsel && hwrite && htrans == FCPM_HTRANS_NSEQ
                                    && haddr[7:0] == FCPM_CTRL_ADDR;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ram_clear;
    wr_ctrl_reg && hready && cpu_in_ram && !hwdata[FCPM_MAN_BIT] && !mode_events.nmi;
  endsequence
  sequence s_blocked_req;
    flash_req.req && !warmup_ready_flag;
  endsequence

  a_clear_cuts_power: assert property (s_ram_clear |=> !flash_power_on && !warmup_ready_flag)
    else $error("power stayed on after clear");
  a_ready_has_power: assert property (warmup_ready_flag |-> flash_power_on)
    else $error("ready without power");
  a_off_clears_ready: assert property ($fell(flash_power_on) |-> !warmup_ready_flag)
    else $error("ready kept after power off");
  a_blank_byte: assert property (s_blocked_req |=> flash_rvalid && flash_rdata == FCPM_BLANK_BYTE)
    else $error("blocked read not blank");
  a_fetch_trap: assert property (s_blocked_req ##0 flash_req.fetch |=> soft_interrupt)
    else $error("blocked fetch gave no trap");
  a_raw_byte: assert property (flash_req.req && warmup_ready_flag |=> flash_rdata == $past(flash_req.rdata))
    else $error("ready read not raw");
  a_hold_follows: assert property (interrupt_hold == cpu_stall)
    else $error("interrupt hold differs from stall");
  a_stall_warming: assert property (cpu_stall |-> flash_power_on && !warmup_ready_flag)
    else $error("stall outside warm-up");
  a_release_ready: assert property ($fell(cpu_stall) |-> warmup_ready_flag)
    else $error("stall released early");
  a_stop_cuts: assert property (mode_events.stop_enter && !cpu_stall |=> !flash_power_on)
    else $error("stop kept power");
endmodule : fcpm_properties

bind fcpm_power_manager fcpm_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .cpu_in_ram, .mode_events, .flash_req, .flash_power_on,
  .warmup_ready_flag, .cpu_stall, .interrupt_hold, .flash_rdata, .flash_rvalid, .soft_interrupt);

`default_nettype wire

// *** bench/fcpm_osc_model.sv ***
`default_nettype none

// free-running oscillators, unrelated in phase to hclk
module fcpm_osc_model #(
  parameter real FAST_HALF = 30.3,
  parameter real SLOW_HALF = 100.7
) (
  output logic fast_clock,
  output logic slow_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    fast_clock = 1'b0;
    slow_clock = 1'b0;
  end
  always #(FAST_HALF) fast_clock = ~fast_clock;
  always #(SLOW_HALF) slow_clock = ~slow_clock;
endmodule : fcpm_osc_model

`default_nettype wire

// *** bench/testbench.sv ***
`default_nettype none

module testbench
  import fcpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam real FH     = 30.3;
  localparam real SH     = 100.7;
  localparam real FAST_E = (2.0 ** FCPM_FAST_EXP) * FH / 10.0;
  localparam real SLOW_E = (2.0 ** FCPM_SLOW_EXP) * SH / 10.0;
  logic            hclk, hresetn, hsel, hwrite, cpu_in_ram, system_clock_select;
  logic [31:0]     haddr, hwdata, hrdata;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  fcpm_mode_t      mode_events;
  fcpm_flash_req_t flash_req;
  wire logic       hready, fast_clock, slow_clock;
  logic            hreadyout, hresp, flash_power_on, warmup_ready_flag, cpu_stall;
  logic            interrupt_hold, flash_rvalid, soft_interrupt;
  logic [7:0]      flash_rdata;
  int              num_errors = 0;
  int              cmp_count = 0;

  assign hready = hreadyout;
  always #10 hclk = ~hclk;

  fcpm_osc_model #(.FAST_HALF(FH), .SLOW_HALF(SH)) u_osc (.fast_clock, .slow_clock);
  fcpm_power_manager DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .cpu_in_ram, .system_clock_select, .mode_events,
    .flash_req, .fast_clock, .slow_clock, .flash_power_on, .warmup_ready_flag, .cpu_stall,
    .interrupt_hold, .flash_rdata, .flash_rvalid, .soft_interrupt);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= FCPM_HTRANS_NSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(a, 1'b0, 32'h0);
    chk(nm, hrdata, exp);
    chk("hresp okay", hresp, 1'b0);
    #1;
  endtask : rd

  task automatic ev(input logic [4:0] v);
    mode_events <= fcpm_mode_t'(v);
    @(posedge hclk);
    mode_events <= fcpm_mode_t'(5'h00);
    #1;
  endtask : ev

  task automatic fr(input logic fetch, input logic [7:0] raw, input logic ok);
    flash_req <= fcpm_flash_req_t'({1'b1, fetch, raw});
    @(posedge hclk);
    flash_req <= fcpm_flash_req_t'({2'b00, ~raw});
    #1;
    chk("flash byte", flash_rdata, ok ? raw : FCPM_BLANK_BYTE);
    chk("soft irq", {flash_rvalid, soft_interrupt}, {1'b1, fetch & ~ok});
  endtask : fr

  // software polls ready; e is the expected span in hclk cycles
  task automatic warm(input logic stall, input real e, input real per);
    int   n = 0;
    logic bad = 1'b0;
    while (warmup_ready_flag !== 1'b1 && n < 4000) begin
      bad |= (cpu_stall !== stall);
      bad |= (interrupt_hold !== stall);
      @(posedge hclk);
      #1;
      n++;
    end
    chk("stall in warm-up", bad, 1'b0);
    chk("warm-up span", n >= e - per - 1 && n <= e + 8, 1'b1);
    chk("stall released", cpu_stall, 1'b0);
  endtask : warm

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(FCPM_CTRL_ADDR, 32'h1, "ctrl reset");
    rd(FCPM_STATUS_ADDR, 32'h2, "status reset");
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0, "unmapped");
    fr(1'b1, 8'h5a, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_manual(input logic slow);
    system_clock_select <= slow;
    wr(FCPM_CTRL_ADDR, 32'h0);
    chk("power off", {flash_power_on, warmup_ready_flag}, 2'b00);
    fr(1'b1, 8'h3c, 1'b0);
    cpu_in_ram <= 1'b0;
    wr(FCPM_CTRL_ADDR, 32'h1);
    rd(FCPM_CTRL_ADDR, 32'h0, "write from flash");
    cpu_in_ram <= 1'b1;
    wr(FCPM_CTRL_ADDR, 32'h1);
    warm(1'b0, slow ? SLOW_E : FAST_E, slow ? SH / 10.0 : FH / 10.0);
    fr(1'b0, 8'hc3, 1'b1);
    $display("test manual done");
  endtask : t_manual

  task automatic t_auto;
    cpu_in_ram <= 1'b0;
    wr(FCPM_CTRL_ADDR, 32'h3);
    cpu_in_ram <= 1'b1;
    rd(FCPM_CTRL_ADDR, 32'h3, "auto from flash");
    ev(5'h04);
    ev(5'h02);
    chk("auto bit set", {flash_power_on, cpu_stall}, 2'b10);
    wr(FCPM_CTRL_ADDR, 32'h1);
    ev(5'h04);
    chk("halt off", flash_power_on, 1'b0);
    ev(5'h02);
    warm(1'b1, FAST_E, FH / 10.0);
    wr(FCPM_CTRL_ADDR, 32'h0);
    ev(5'h04);
    ev(5'h02);
    chk("manual off halt", {flash_power_on, cpu_stall}, 2'b00);
    $display("test auto done");
  endtask : t_auto

  task automatic t_nmi;
    ev(5'h01);
    warm(1'b1, FAST_E, FH / 10.0);
    rd(FCPM_CTRL_ADDR, 32'h1, "nmi sets manual");
    wr(FCPM_CTRL_ADDR, 32'h0);
    wr(FCPM_CTRL_ADDR, 32'h1);
    repeat (50) @(posedge hclk);
    ev(5'h01);
    warm(1'b1, FAST_E - 51.0, FH / 10.0);
    $display("test nmi done");
  endtask : t_nmi

  task automatic t_stop;
    ev(5'h10);
    chk("stop off", flash_power_on, 1'b0);
    repeat (20) @(posedge hclk);
    ev(5'h08);
    warm(1'b1, FAST_E, FH / 10.0);
    wr(FCPM_CTRL_ADDR, 32'h0);
    ev(5'h10);
    ev(5'h08);
    chk("stop manual off", {flash_power_on, cpu_stall}, 2'b00);
    $display("test stop done");
  endtask : t_stop

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cpu_in_ram = 1'b1;
    system_clock_select = 1'b0;
    mode_events = fcpm_mode_t'(5'h00);
    flash_req = fcpm_flash_req_t'(10'h0);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_manual(1'b1);
    t_manual(1'b0);
    t_auto;
    t_nmi;
    t_stop;
    complete_run;
  end

  initial begin
    #1000000;
    num_errors++;
    complete_run;
  end
endmodule : testbench

`default_nettype wire
